// ### rtl/strap_latch_pkg.sv
// Shared constants and types for the reset strap option latch
package strap_latch_pkg;

  // Pin positions within the seven shared strap pins
  localparam int PIN_BOOT_SEL   = 0;
  localparam int PIN_BUS_MASTER = 1;
  localparam int PIN_TIMER_EXP  = 2;
  localparam int PIN_BUS_HOLD   = 3;
  localparam int PIN_LINK1_DONE = 4;
  localparam int PIN_LINK2_DONE = 5;
  localparam int PIN_LINK3_DONE = 6;
  localparam int PIN_COUNT      = 7;

  // Pins that become plain driven outputs once released
  localparam logic [6:0] DRIVEN_AFTER_RESET = 7'h76;
  // Pins with a pull-down during reset on processor ID 0 only
  localparam logic [6:0] PULL_DOWN_ID0      = 7'h09;
  // Pins with a pull-down during reset on every processor
  localparam logic [6:0] PULL_DOWN_ALWAYS   = 7'h06;
  // Pins with a pull-up during reset
  localparam logic [6:0] PULL_UP_IN_RESET   = 7'h70;
  // Pins with a pull-up after reset on processor ID 0 only
  localparam logic [6:0] PULL_UP_ID0_AFTER  = 7'h09;

  // Value latched before any capture, equal to the pull defaults
  localparam logic [6:0] STRAP_RESET_VALUE  = 7'h70;

  // Release delay after the capture edge
  localparam int RELEASE_NS     = 100;
  localparam int CLOCK_MHZ      = 20;
  localparam int RELEASE_CYCLES = (RELEASE_NS * CLOCK_MHZ + 999) / 1000;
  localparam logic [3:0] RELEASE_COUNT = 4'(RELEASE_CYCLES);

  // Register map, byte addresses
  localparam logic [11:0] ADDR_STATUS     = 12'h000;
  localparam logic [11:0] ADDR_SYS_CONFIG = 12'h004;
  localparam logic [11:0] ADDR_SDR_CONFIG = 12'h008;

  // Status register fields
  localparam int STAT_STRAP_LSB   = 0;
  localparam int STAT_RELEASED    = 8;
  localparam int STAT_SYS_LOCKED  = 9;
  localparam int STAT_SDR_LOCKED  = 10;

  localparam logic [31:0] SYS_CONFIG_RESET = 32'h0000_0000;
  localparam logic [31:0] SDR_CONFIG_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {
    PHASE_HELD   = 2'b00,
    PHASE_SETTLE = 2'b01,
    PHASE_RUN    = 2'b10
  } phase_type;

  typedef struct packed {
    logic test_mode_strap_c;
    logic test_mode_strap_b;
    logic test_mode_strap_a;
    logic config_write_policy_strap;
    logic link_input_width_strap;
    logic interrupt_enable_strap;
    logic boot_source_strap;
  } strap_set_type;

  typedef struct packed {
    logic [6:0] pin_out;
    logic [6:0] pin_oe;
    logic [6:0] pull_up_en;
    logic [6:0] pull_down_en;
  } pad_ctrl_type;

endpackage : strap_latch_pkg

// ### rtl/reset_strap_option_latch.sv
// Reset strap capture, pin handover and config write policy with APB access
// How it works
// - Sample all strap pins on the rising edge of the active-low reset input.
// - Hold each captured strap level as the operating mode setting.
// - Shortly after reset release, hand each strap pin back to its normal role.
// - Undriven strap pins, bar boot-select and bus-hold off ID 0, read their internal pull level, which gets captured.
// - Boot strap 0 starts EPROM boot at release; 1 waits for external boot.
// - Interrupt strap 0 leaves four lines off and edge; 1 enables level mode.
// - Link width strap 0 selects 1-bit input width; 1 selects 4-bit.
// - Config strap 0 allows one write per reset to config registers; 1 always.
// - Boot-select and bus-hold pulled down then up on ID 0; others driven after.
module reset_strap_option_latch
  import strap_latch_pkg::*;
(
  // Clock and resets
  input  wire logic          mclk,
  input  wire logic          rst,
  input  wire logic          reset_in_n,
  input  wire logic [2:0]    processor_id,

  // Shared strap pins and pad control
  input  wire logic [6:0]    pin_in,
  output logic      [6:0]    pin_out,
  output logic      [6:0]    pin_oe,
  output logic      [6:0]    pull_up_en,
  output logic      [6:0]    pull_down_en,
  input  wire logic [6:0]    func_out,
  input  wire logic [6:0]    func_oe,

  // Latched modes
  output strap_set_type      straps,
  output logic               pins_released,
  output logic               boot_eprom_start,
  output logic               boot_wait_external,
  output logic [3:0]         external_interrupt_lines_enable,
  output logic [3:0]         external_interrupt_lines_level,
  output logic               link_input_width_4bit,
  output logic [31:0]        system_config_reg,
  output logic [31:0]        sdram_config_reg,

  // Register bus
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr
);

  phase_type     phase;
  phase_type     next_phase;
  logic          reset_in_prev;
  logic [3:0]    settle_count;
  logic [3:0]    next_settle_count;
  logic          sys_written;
  logic          sdr_written;
  logic          boot_pulse;
  wire pad_ctrl_type pads;

  wire logic     id_zero       = (processor_id == 3'h0);
  wire logic     release_edge  = reset_in_n && !reset_in_prev;
  wire logic     in_reset      = !reset_in_n;
  wire logic     run_phase     = (phase == PHASE_RUN);

  // Rising edge of the reset input taken on mclk; the input is synchronous
  always_ff @(posedge mclk) begin
    if (rst) begin
      reset_in_prev <= 1'b0;
    end else begin
      reset_in_prev <= reset_in_n;
    end
  end

  // Capture only at the release edge, never while reset is held
  always_ff @(posedge mclk) begin
    if (rst) begin
      straps <= strap_set_type'(STRAP_RESET_VALUE);
    end else if (release_edge) begin
      straps <= strap_set_type'(pin_in);
    end
  end

  // Phase sequencing: held, short settle, then normal pin use
  always_comb begin
    next_phase        = phase;
    next_settle_count = settle_count;
    case (phase)
      PHASE_HELD: begin
        if (release_edge) begin
          next_phase        = PHASE_SETTLE;
          next_settle_count = RELEASE_COUNT;
        end
      end
      PHASE_SETTLE: begin
        if (in_reset) begin
          next_phase = PHASE_HELD;
        end else if (settle_count <= 4'h1) begin
          next_phase        = PHASE_RUN;
          next_settle_count = 4'h0;
        end else begin
          next_settle_count = settle_count - 4'h1;
        end
      end
      PHASE_RUN: begin
        if (in_reset) begin
          next_phase = PHASE_HELD;
        end
      end
      default: begin
        next_phase = PHASE_HELD;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      phase        <= PHASE_HELD;
      settle_count <= 4'h0;
    end else begin
      phase        <= next_phase;
      settle_count <= next_settle_count;
    end
  end

  // One slice per shared pin; pulls stay on until release so undriven pins, bar boot-select and bus-hold off ID 0, read defaults
  genvar pin;
  generate
    for (pin = 0; pin < PIN_COUNT; pin++) begin : g_pad
      wire logic always_driven = DRIVEN_AFTER_RESET[pin];
      wire logic down_in_reset = PULL_DOWN_ALWAYS[pin] || (id_zero && PULL_DOWN_ID0[pin]);
      wire logic up_in_reset   = PULL_UP_IN_RESET[pin];
      wire logic up_after      = id_zero && PULL_UP_ID0_AFTER[pin];

      // Functional drive only once released, so a strap never fights the board
      assign pads.pin_out[pin]      = run_phase && func_out[pin];
      assign pads.pin_oe[pin]       = run_phase && (always_driven || func_oe[pin]);
      // Test mode pins are pulled up only until release; the board must leave them alone
      assign pads.pull_up_en[pin]   = run_phase ? up_after : up_in_reset;
      assign pads.pull_down_en[pin] = !run_phase && down_in_reset;
    end
  endgenerate

  always_ff @(posedge mclk) begin
    if (rst) begin
      pin_out      <= 7'h00;
      pin_oe       <= 7'h00;
      pull_up_en   <= 7'h00;
      pull_down_en <= 7'h00;
    end else begin
      pin_out      <= pads.pin_out;
      pin_oe       <= pads.pin_oe;
      pull_up_en   <= pads.pull_up_en;
      pull_down_en <= pads.pull_down_en;
    end
  end

  // Release status and boot pulse from the phase; mode outputs decoded from the latched straps
  assign pins_released                   = (phase == PHASE_RUN);
  assign boot_pulse                      = (next_phase == PHASE_RUN) && (phase == PHASE_SETTLE);
  assign boot_wait_external              = straps.boot_source_strap;
  assign external_interrupt_lines_enable = {4{straps.interrupt_enable_strap}};
  assign external_interrupt_lines_level  = {4{straps.interrupt_enable_strap}};
  assign link_input_width_4bit           = straps.link_input_width_strap;

  // One pulse as the pins are released when booting from EPROM
  always_ff @(posedge mclk) begin
    if (rst) begin
      boot_eprom_start <= 1'b0;
    end else begin
      boot_eprom_start <= boot_pulse && !straps.boot_source_strap;
    end
  end

  // Full twelve-bit match; partial decoding would alias the status word
  function automatic logic addr_is(
    input logic [11:0] addr,
    input logic [11:0] target
  );
    return (addr == target);
  endfunction

  // Policy strap 1 keeps a register open for good
  function automatic logic write_allowed(
    input logic always_open,
    input logic written
  );
    return always_open || !written;
  endfunction

  // Status word layout kept in one place
  function automatic logic [31:0] status_word(
    input strap_set_type s,
    input logic          released,
    input logic          sys_lock,
    input logic          sdr_lock
  );
    logic [31:0] word;
    word                              = 32'h0000_0000;
    word[STAT_STRAP_LSB +: PIN_COUNT] = s;
    word[STAT_RELEASED]               = released;
    word[STAT_SYS_LOCKED]             = sys_lock;
    word[STAT_SDR_LOCKED]             = sdr_lock;
    return word;
  endfunction

  // APB decode
  wire logic apb_setup   = psel && !penable;
  wire logic apb_access  = psel && penable;
  wire logic hit_status  = addr_is(paddr, ADDR_STATUS);
  wire logic hit_sys     = addr_is(paddr, ADDR_SYS_CONFIG);
  wire logic hit_sdr     = addr_is(paddr, ADDR_SDR_CONFIG);
  wire logic hit_any     = hit_status || hit_sys || hit_sdr;
  wire logic sys_open    = write_allowed(straps.config_write_policy_strap, sys_written);
  wire logic sdr_open    = write_allowed(straps.config_write_policy_strap, sdr_written);
  wire logic write_sys   = apb_access && pwrite && hit_sys && sys_open;
  wire logic write_sdr   = apb_access && pwrite && hit_sdr && sdr_open;
  wire logic write_bad   = pwrite && ((hit_sys && !sys_open) || (hit_sdr && !sdr_open) || hit_status);

  logic [31:0] read_value;
  always_comb begin
    read_value = 32'h0000_0000;
    if (hit_status) begin
      read_value = status_word(straps, pins_released, !sys_open, !sdr_open);
    end else if (hit_sys) begin
      read_value = system_config_reg;
    end else if (hit_sdr) begin
      read_value = sdram_config_reg;
    end
  end

  // Zero wait states; unmapped, status writes and locked writes answer an error
  assign pready  = 1'b1;
  assign pslverr = apb_access && (!hit_any || write_bad);

  always_ff @(posedge mclk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (apb_setup && !pwrite) begin
      prdata <= read_value;
    end
  end

  // Register contents; a write lands at the access edge
  always_ff @(posedge mclk) begin
    if (rst) begin
      system_config_reg <= SYS_CONFIG_RESET;
    end else if (write_sys) begin
      system_config_reg <= pwdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      sdram_config_reg <= SDR_CONFIG_RESET;
    end else if (write_sdr) begin
      sdram_config_reg <= pwdata;
    end
  end

  // Write-once tracking rearms every time reset is held; writes in reset do not count
  always_ff @(posedge mclk) begin
    if (rst || in_reset) begin
      sys_written <= 1'b0;
    end else begin
      sys_written <= sys_written || write_sys;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst || in_reset) begin
      sdr_written <= 1'b0;
    end else begin
      sdr_written <= sdr_written || write_sdr;
    end
  end

endmodule // reset_strap_option_latch

// ### testbench/strap_board_model.sv
// Board model: strap resistors, pad pulls and pad drive
module strap_board_model (
  input  wire logic       mclk,
  input  wire logic [6:0] pin_out,
  input  wire logic [6:0] pin_oe,
  input  wire logic [6:0] pull_up_en,
  input  wire logic [6:0] pull_down_en,
  input  wire logic [6:0] strap_en,
  input  wire logic [6:0] strap_val,
  output logic      [6:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [6:0] last = 7'h00;
  // Test straps never overdriven
  wire  [6:0] ext = strap_en & 7'h0f;
  always @(posedge mclk) last <= pin_in;
  // Floating pin toggles, so a stale level cannot pass
  always_comb begin
    for (int i = 0; i < 7; i++)
      pin_in[i] = pin_oe[i] ? pin_out[i] : ext[i] ? strap_val[i] : pull_up_en[i] ? 1'b1 :
                  pull_down_en[i] ? 1'b0 : ~last[i];
  end
endmodule // strap_board_model

// ### testbench/reset_strap_option_latch_assertions.sv
// Checker for strap capture and pad handover
module reset_strap_option_latch_assertions
  import strap_latch_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic reset_in_n,
  input wire logic [2:0] processor_id,
  input wire logic [6:0] pin_in,
  input wire logic [6:0] pin_out,
  input wire logic [6:0] pin_oe,
  input wire logic [6:0] pull_up_en,
  input wire logic [6:0] pull_down_en,
  input wire logic [6:0] func_out,
  input wire logic [6:0] func_oe,
  input wire strap_set_type straps,
  input wire logic pins_released,
  input wire logic boot_eprom_start,
  input wire logic boot_wait_external,
  input wire logic [3:0] external_interrupt_lines_enable,
  input wire logic link_input_width_4bit
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (rst);
  sequence cap;
    reset_in_n && !$past(reset_in_n);
  endsequence
  a_strap_capture: assert property (cap |=> straps == $past(pin_in))
    else $error("capture wrong");
  a_strap_hold: assert property (
    !$past(rst) && (!reset_in_n || $past(reset_in_n)) |=> $stable(straps)) else $error("straps moved");
  a_mode_follow: assert property (boot_wait_external == straps.boot_source_strap &&
    external_interrupt_lines_enable == {4{straps.interrupt_enable_strap}} &&
    link_input_width_4bit == straps.link_input_width_strap) else $error("mode outputs wrong");
  a_release_wait: assert property (cap |=> !pins_released [*2]) else $error("early release");
  a_release_run: assert property (cap ##1 reset_in_n [*2] |=> pins_released)
    else $error("no release");
  a_held_drop: assert property (!reset_in_n |=> !pins_released) else $error("held but released");
  a_pulls_held: assert property (!$past(rst) && !$past(pins_released) |-> pin_oe == 7'h00 &&
    pull_up_en == 7'h70 && pull_down_en == (7'h06 | ($past(processor_id) == 3'h0 ? 7'h09 : 7'h00)))
    else $error("held pads wrong");
  a_pads_run: assert property (!$past(rst) && $past(pins_released) |-> pull_down_en == 7'h00 &&
    pull_up_en == ($past(processor_id) == 3'h0 ? 7'h09 : 7'h00) && (pin_oe & 7'h76) == 7'h76 &&
    ((pin_oe ^ $past(func_oe)) & 7'h09) == 7'h00 && pin_out == $past(func_out)) else $error("run pads wrong");
  a_boot_pulse: assert property (
    boot_eprom_start == ($rose(pins_released) && !straps.boot_source_strap)) else $error("boot pulse wrong");
  c_capture: cover property (cap);
  c_boot_start: cover property (boot_eprom_start);
  c_boot_wait: cover property ($rose(pins_released) && straps.boot_source_strap);
endmodule // reset_strap_option_latch_assertions

bind reset_strap_option_latch reset_strap_option_latch_assertions u_reset_strap_option_latch_assertions (.*);

// ### testbench/test_reset_strap_option_latch.sv
// Bench: strap capture, pad handover, config write policy
module test_reset_strap_option_latch
  import strap_latch_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0, rst = 1'b1, reset_in_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic pready, pslverr, pins_released, boot_eprom_start, boot_wait_external, link_input_width_4bit, err;
  logic [2:0] processor_id = 3'h0;
  logic [3:0] external_interrupt_lines_enable, external_interrupt_lines_level;
  logic [6:0] pin_in, pin_out, pin_oe, pull_up_en, pull_down_en;
  logic [6:0] func_out = 7'h00, func_oe = 7'h00, strap_en = 7'h00, strap_val = 7'h00;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, system_config_reg, sdram_config_reg, rd;
  strap_set_type straps;
  int seed = 77, fail_count = 0, tests_run = 0, exp, wa, wb;
  reset_strap_option_latch u_reset_strap_option_latch (.*);
  strap_board_model u_strap_board_model (.*);
  always #25 mclk = ~mclk;
  always @(posedge mclk) begin
    func_out <= 7'($random(seed));
    func_oe <= 7'($random(seed));
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic compare(input string what, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic expect_high(input logic s);
    if (s !== 1'b1) begin
      fail_count++;
      conclude();
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    for (int n = 0; n < 9; n++) begin
      @(posedge mclk);
      if (pready === 1'b1)
        break;
    end
    expect_high(pready);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  initial begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    for (int t = 0; t < 6; t++) begin
      reset_in_n <= 1'b0;
      processor_id <= (t % 3 == 2) ? 3'($random(seed)) | 3'h1 : 3'h0;
      strap_en <= 7'($random(seed)) | (t % 3 == 2 ? 7'h09 : 7'h00);
      repeat (5) begin
        @(posedge mclk);
        strap_val <= 7'($random(seed));
      end
      reset_in_n <= 1'b1;
      @(posedge mclk);
      // Taken after the capture edge, once the last strap values have settled
      exp = (strap_en & strap_val & 7'h0f) | 7'h70;
      strap_val <= ~strap_val;
      for (int i = 0; i < 9 && pins_released !== 1'b1; i++)
        @(posedge mclk);
      expect_high(pins_released);
      @(posedge mclk);
      compare("straps", exp, 32'(straps));
      compare("modes", {exp[2], {8{exp[1]}}, exp[0]}, {link_input_width_4bit,
        external_interrupt_lines_enable, external_interrupt_lines_level, boot_wait_external});
      compare("pull_up", processor_id == 3'h0 ? 7'h09 : 7'h00, pull_up_en);
      for (int r = 1; r < 3; r++) begin
        wa = $random(seed);
        wb = $random(seed);
        apb(1'b1, 12'(4 * r), wa);
        apb(1'b1, 12'(4 * r), wb);
        compare("lock_err", !exp[3], err);
        apb(1'b0, 12'(4 * r), 32'h0);
        compare("config", exp[3] ? wb : wa, rd);
      end
      $display("test %0d done", t);
    end
    apb(1'b0, 12'h00c, 32'h0);
    compare("unmapped_err", 32'h1, err);
    conclude();
  end
endmodule // test_reset_strap_option_latch
